// ### fill_framer.sv
// host-side framer: sends a tag fill command and checks the reply
// Function
// - packets framed by 02h 02h and 03h
// - size word counts code and parameters only
// - two-byte fields go MSB first
// - body bytes are raw binary, unescaped
// - size word independent of checksum presence
// - checksum is FFh minus byte sum
// - size through checksum must sum FFh
// - no software flow control on link
// - fill code 04h, address, length, timeout, value
// - timeout in ms, 1Eh to FFFEh; out-of-range values are still sent, with o_range_warn set
// - accept packets without data field
`timescale 1ns/1ps
`default_nettype none
module fill_framer #(
  parameter int SLACK_MS = 1000,
  // clock cycles in one millisecond; a bench may shorten it to keep runs brief
  parameter int MS_TICKS = framer_pkg::MS_CYCLES
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  // command request from the user
  input  wire logic        i_start,
  input  wire logic [15:0] i_addr,
  input  wire logic [15:0] i_len,
  input  wire logic [15:0] i_tmo_ms,
  input  wire logic [7:0]  i_value,
  input  wire logic        i_csum_en,
  // byte link towards the reader (tx)
  output logic             o_tx_valid,
  output logic [7:0]       o_tx_data,
  input  wire logic        i_tx_ready,
  // byte link from the reader (rx, from a uart on this clock)
  input  wire logic        i_rx_valid,
  input  wire logic [7:0]  i_rx_data,
  // result
  output logic             o_busy,
  output logic             o_done,
  output logic             o_ok,
  output logic [7:0]       o_err_code,
  output logic             o_range_warn
);
  typedef enum logic [1:0] {
    F_IDLE = 2'b00,
    F_SEND = 2'b01,
    F_WAIT = 2'b11
  } fstate_t;

  // with the checksum on, the end byte sits one slot past the checksum slot
  localparam logic [4:0] LAST_IDX = 5'(framer_pkg::FILL_BYTES + 1);

  fstate_t     st_ff;
  logic [7:0]  body_ff [framer_pkg::FILL_BYTES];
  logic [4:0]  idx_ff;
  logic        csum_en_ff;
  logic [7:0]  sum_ff;
  logic [16:0] ms_left_ff;
  logic [16:0] tick_ff;
  logic        tx_fire;
  logic        ms_tick;
  logic [7:0]  nxt_byte;
  logic        parser_clr;

  // reply matches a fill success: echo of the code and a size word of one
  function automatic logic echo_good(input logic [7:0] code, input logic [15:0] size);
    echo_good = (code == framer_pkg::FILL_CODE) && (size == 16'h0001);
  endfunction

  // a reply cut short by the deadline must not leave the parser mid-frame
  assign parser_clr = i_srst || (st_ff != F_WAIT);

  rx_if rx ();

  reply_parser u_parser (
    .i_clk      (i_clk),
    .i_srst     (parser_clr),
    .i_csum_en  (csum_en_ff),
    .i_rx_valid (i_rx_valid && st_ff == F_WAIT),
    .i_rx_data  (i_rx_data),
    .res        (rx)
  );

  // pacing is i_tx_ready alone: no xon/xoff, control codes may ride in data
  assign tx_fire = o_tx_valid && i_tx_ready;
  assign ms_tick = (tick_ff == 17'(MS_TICKS - 1));

  // byte select for the outgoing command: 0..11 body, then csum, then end
  always_comb begin
    nxt_byte = framer_pkg::END_BYTE;
    if (idx_ff < 5'(framer_pkg::FILL_BYTES)) begin
      nxt_byte = body_ff[idx_ff[3:0]];
    end else if (idx_ff == 5'(framer_pkg::FILL_BYTES) && csum_en_ff) begin
      nxt_byte = framer_pkg::csum_of(sum_ff);
    end
  end

  // command capture and transmit sequencing
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_ff      <= F_IDLE;
      idx_ff     <= '0;
      csum_en_ff <= 1'b0;
      sum_ff     <= '0;
      o_tx_valid <= 1'b0;
      o_tx_data  <= '0;
      for (int i = 0; i < framer_pkg::FILL_BYTES; i++) body_ff[i] <= '0;
    end else begin
      case (st_ff)
        F_IDLE: begin
          if (i_start) begin
            // header, size, code, then MSB-first parameters; size fixed at 8
            body_ff[0]  <= framer_pkg::START_BYTE;
            body_ff[1]  <= framer_pkg::START_BYTE;
            body_ff[2]  <= framer_pkg::FILL_SIZE[15:8];
            body_ff[3]  <= framer_pkg::FILL_SIZE[7:0];
            body_ff[4]  <= framer_pkg::FILL_CODE;
            body_ff[5]  <= i_addr[15:8];
            body_ff[6]  <= i_addr[7:0];
            body_ff[7]  <= i_len[15:8];
            body_ff[8]  <= i_len[7:0];
            body_ff[9]  <= i_tmo_ms[15:8];
            body_ff[10] <= i_tmo_ms[7:0];
            body_ff[11] <= i_value;
            csum_en_ff  <= i_csum_en;
            sum_ff      <= '0;
            idx_ff      <= '0;
            o_tx_valid  <= 1'b1;
            o_tx_data   <= framer_pkg::START_BYTE;
            st_ff       <= F_SEND;
          end
        end
        F_SEND: begin
          if (tx_fire) begin
            // sum covers size word through fill value (indices 2..11)
            if (idx_ff >= 5'd2 && idx_ff < 5'(framer_pkg::FILL_BYTES)) begin
              sum_ff <= sum_ff + o_tx_data;
            end
            if (idx_ff == LAST_IDX || (idx_ff == 5'(framer_pkg::FILL_BYTES) && !csum_en_ff)) begin
              o_tx_valid <= 1'b0;
              st_ff      <= F_WAIT;
            end else begin
              idx_ff <= idx_ff + 5'd1;
            end
          end
          // present the following byte once the sum is updated
          if (!tx_fire && o_tx_valid) begin
            o_tx_data <= nxt_byte;
          end
        end
        F_WAIT: begin
          if (rx.done || ms_left_ff == '0) st_ff <= F_IDLE;
        end
        default: st_ff <= F_IDLE;
      endcase
    end
  end

  // millisecond divider and reply deadline: device timeout plus host slack
  always_ff @(posedge i_clk) begin
    if (i_srst || st_ff != F_WAIT) begin
      tick_ff <= '0;
    end else begin
      tick_ff <= ms_tick ? '0 : tick_ff + 17'd1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ms_left_ff <= '0;
    end else if (st_ff == F_IDLE && i_start) begin
      ms_left_ff <= {1'b0, i_tmo_ms} + 17'(SLACK_MS);
    end else if (st_ff == F_WAIT && ms_tick && ms_left_ff != '0) begin
      ms_left_ff <= ms_left_ff - 17'd1;
    end
  end

  // result reporting
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_busy       <= 1'b0;
      o_done       <= 1'b0;
      o_ok         <= 1'b0;
      o_err_code   <= '0;
      o_range_warn <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (st_ff == F_IDLE && i_start) begin
        o_busy       <= 1'b1;
        // out-of-range is still sent; zero must draw the reader's syntax error
        o_range_warn <= (i_tmo_ms < framer_pkg::TMO_MIN) || (i_tmo_ms > framer_pkg::TMO_MAX);
      end
      if (st_ff == F_WAIT && rx.done) begin
        o_busy <= 1'b0;
        o_done <= 1'b1;
        if (!rx.ok) begin
          o_ok       <= 1'b0;
          o_err_code <= framer_pkg::ERR_CHECKSUM;
        end else if (rx.is_err) begin
          o_ok       <= 1'b0;
          o_err_code <= rx.err_code;
        end else begin
          o_ok       <= echo_good(rx.code, rx.size);
          o_err_code <= echo_good(rx.code, rx.size) ? 8'h00 : framer_pkg::ERR_FRAME;
        end
      end else if (st_ff == F_WAIT && ms_left_ff == '0) begin
        o_busy     <= 1'b0;
        o_done     <= 1'b1;
        o_ok       <= 1'b0;
        o_err_code <= framer_pkg::ERR_TIMEOUT;
      end
    end
  end
endmodule
`default_nettype wire

// ### fill_framer_asserts.sv
// port-level checks on the host-side fill framer
`timescale 1ns/1ps
`default_nettype none
module fill_framer_asserts (
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_srst,
  // request
  input wire logic        i_start,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_len,
  input wire logic [15:0] i_tmo_ms,
  input wire logic [7:0]  i_value,
  input wire logic        i_csum_en,
  // byte links
  input wire logic        o_tx_valid,
  input wire logic [7:0]  o_tx_data,
  input wire logic        i_tx_ready,
  input wire logic        i_rx_valid,
  input wire logic [7:0]  i_rx_data,
  // result
  input wire logic        o_busy,
  input wire logic        o_done,
  input wire logic        o_ok,
  input wire logic [7:0]  o_err_code,
  input wire logic        o_range_warn
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  AST_START_HDR: assert property (i_start && !o_busy |=> o_busy && o_tx_valid
    && o_tx_data == framer_pkg::START_BYTE) else $error("first byte not a start byte");
  AST_END_LAST: assert property ($fell(o_tx_valid) |->
    $past(o_tx_data) == framer_pkg::END_BYTE && $past(i_tx_ready)) else $error("bad last byte");
  AST_IDLE_QUIET: assert property (!o_busy |-> !o_tx_valid)
    else $error("byte offered while idle");
  AST_BUSY_CAUSE: assert property ($rose(o_busy) |-> $past(i_start))
    else $error("busy without a start");
  AST_DONE_PULSE: assert property (o_done |=> !o_done && !o_busy)
    else $error("done not a single pulse");
  AST_OK_CODE: assert property (o_done && o_ok |-> o_err_code == 8'h00)
    else $error("error code set on success");
  AST_FAULT_CODE: assert property (o_done && !o_ok |-> o_err_code != 8'h00)
    else $error("fault without a code");
  AST_RANGE_WARN: assert property (i_start && !o_busy |=> o_range_warn ==
    ($past(i_tmo_ms) < framer_pkg::TMO_MIN || $past(i_tmo_ms) > framer_pkg::TMO_MAX))
    else $error("range warning wrong");
  AST_DONE_AFTER_END: assert property (o_done && o_err_code != framer_pkg::ERR_TIMEOUT |->
    $past(i_rx_valid, 2) && $past(i_rx_data, 2) == framer_pkg::END_BYTE)
    else $error("done not tied to end byte");
endmodule
`default_nettype wire

// ### fill_framer_test.sv
// self-checking bench for the host-side fill framer
`timescale 1ns/1ps
`default_nettype none
module fill_framer_test;
  logic        i_clk = 1'b0;
  logic        i_srst = 1'b1;
  logic        i_start = 1'b0;
  logic        i_csum_en = 1'b0;
  logic [15:0] i_addr = 16'h0000;
  logic [15:0] i_len = 16'h0000;
  logic [15:0] i_tmo_ms = 16'h0000;
  logic [7:0]  i_value = 8'h00;
  logic [1:0]  mode = 2'h0;
  logic        i_tx_ready, i_rx_valid, o_tx_valid, o_busy, o_done, o_ok, o_range_warn;
  logic [7:0]  i_rx_data, o_tx_data, o_err_code;
  logic [7:0]  exp [$];
  int          err_count = 0;
  int          total_checks = 0;
  initial forever #4 i_clk = ~i_clk;
  // a short millisecond and slack keep the overrun case near a thousand cycles
  fill_framer #(.SLACK_MS(1), .MS_TICKS(1000)) fill_framer_i (.i_clk(i_clk), .i_srst(i_srst),
    .i_start(i_start),
    .i_addr(i_addr), .i_len(i_len), .i_tmo_ms(i_tmo_ms), .i_value(i_value),
    .i_csum_en(i_csum_en), .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data),
    .i_tx_ready(i_tx_ready), .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data), .o_busy(o_busy),
    .o_done(o_done), .o_ok(o_ok), .o_err_code(o_err_code), .o_range_warn(o_range_warn));
  tag_reader_model tag_reader_model_i (.i_clk(i_clk), .i_tx_valid(o_tx_valid),
    .i_tx_data(o_tx_data), .o_tx_ready(i_tx_ready), .o_rx_valid(i_rx_valid),
    .o_rx_data(i_rx_data), .i_csum_en(i_csum_en), .i_mode(mode));
  task chk(input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want) begin
      err_count++;
      $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task finish_test;
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task run(input logic [15:0] a, l, t, input logic [7:0] v, input logic c, input logic [1:0] m);
    int n;
    logic [7:0] s;
    exp = {8'h02, 8'h02, 8'h00, 8'h08, 8'h04, a[15:8], a[7:0], l[15:8], l[7:0], t[15:8], t[7:0], v};
    s = 8'h00;
    for (n = 2; n < 12; n++) s += exp[n];
    if (c) exp.push_back(8'hff - s);
    exp.push_back(8'h03);
    tag_reader_model_i.got = {};
    @(posedge i_clk);
    {i_addr, i_len, i_tmo_ms, i_value, i_csum_en, mode, i_start} <= {a, l, t, v, c, m, 1'b1};
    @(posedge i_clk) i_start <= 1'b0;
    // a second start while busy must leave the packet untouched
    @(posedge i_clk) i_start <= 1'b1;
    i_addr <= ~a;
    @(posedge i_clk) i_start <= 1'b0;
    n = 0;
    while (o_done !== 1'b1 && n < 20000) begin
      @(negedge i_clk);
      n++;
    end
    if (n == 20000) begin
      err_count++;
      finish_test();
    end
    chk(tag_reader_model_i.got.size(), exp.size());
    foreach (exp[k]) chk(tag_reader_model_i.got[k], exp[k]);
  endtask
  task t_plain;
    run(16'h0005, 16'h000a, 16'h001e, 8'h41, 1'b0, 2'h0);
    chk({o_ok, o_err_code}, 16'h0100);
    chk(o_range_warn, 1'b0);
    for (int k = 5; k < 15; k++) chk(tag_reader_model_i.mem[k], 8'h41);
    $display("test plain done");
  endtask
  task t_csum;
    run(16'h0302, 16'h0003, 16'hfffe, 8'h03, 1'b1, 2'h0);
    chk({o_ok, o_err_code}, 16'h0100);
    chk(o_range_warn, 1'b0);
    for (int k = 2; k < 5; k++) chk(tag_reader_model_i.mem[k], 8'h03);
    chk(tag_reader_model_i.mem[5], 8'h41);
    $display("test checksum done");
  endtask
  task t_zero;
    run(16'h0000, 16'h0001, 16'h0000, 8'hff, 1'b1, 2'h0);
    chk({o_ok, o_err_code}, 16'h0005);
    chk(o_range_warn, 1'b1);
    $display("test zero timeout done");
  endtask
  task t_fault;
    run(16'h0010, 16'h0001, 16'h0100, 8'h00, 1'b0, 2'h1);
    chk({o_ok, o_err_code}, 16'h0007);
    $display("test fault done");
  endtask
  task t_badcs;
    run(16'h0010, 16'h0001, 16'h0100, 8'h00, 1'b1, 2'h2);
    chk({o_ok, o_err_code}, {8'h00, framer_pkg::ERR_CHECKSUM});
    $display("test bad checksum done");
  endtask
  task t_tmo;
    run(16'h0010, 16'h0001, 16'h0000, 8'h00, 1'b0, 2'h3);
    chk({o_ok, o_err_code}, {8'h00, framer_pkg::ERR_TIMEOUT});
    $display("test overrun done");
  endtask
  initial begin
    repeat (16) @(posedge i_clk);
    i_srst <= 1'b0;
    t_plain();
    t_csum();
    t_zero();
    t_fault();
    t_badcs();
    t_tmo();
    finish_test();
  end
endmodule
bind fill_framer fill_framer_asserts fill_framer_asserts_i (.i_clk(i_clk), .i_srst(i_srst),
  .i_start(i_start), .i_addr(i_addr), .i_len(i_len), .i_tmo_ms(i_tmo_ms), .i_value(i_value),
  .i_csum_en(i_csum_en), .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data),
  .i_tx_ready(i_tx_ready), .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data), .o_busy(o_busy),
  .o_done(o_done), .o_ok(o_ok), .o_err_code(o_err_code), .o_range_warn(o_range_warn));
`default_nettype wire

// ### framer_pkg.sv
// constants and types shared by the host-side command framer
package framer_pkg;
  localparam logic [7:0]  START_BYTE     = 8'h02;
  localparam logic [7:0]  END_BYTE       = 8'h03;
  localparam logic [7:0]  ERR_FLAG       = 8'hFF;
  localparam logic [7:0]  SUM_TARGET     = 8'hFF;
  localparam logic [7:0]  FILL_CODE      = 8'h04;
  localparam logic [15:0] FILL_SIZE      = 16'h0008;
  localparam logic [15:0] TMO_MIN        = 16'h001E;
  localparam logic [15:0] TMO_MAX        = 16'hFFFE;
  localparam int          CLK_MHZ        = 125;
  localparam int          MS_NS          = 1000000;
  localparam int          CLK_NS         = 1000 / CLK_MHZ;
  localparam int          MS_CYCLES      = MS_NS / CLK_NS;
  localparam int          FILL_BYTES     = 12;
  localparam int          RX_MAX         = 64;
  localparam logic [7:0]  ERR_CHECKSUM   = 8'h01;
  localparam logic [7:0]  ERR_FRAME      = 8'h02;
  localparam logic [7:0]  ERR_TIMEOUT    = 8'h03;

  typedef enum logic [2:0] {
    RX_HDR0 = 3'b000,
    RX_HDR1 = 3'b001,
    RX_SZH  = 3'b011,
    RX_SZL  = 3'b010,
    RX_BODY = 3'b110,
    RX_CSUM = 3'b111,
    RX_END  = 3'b101
  } rx_state_t;

  function automatic logic [7:0] csum_of(input logic [7:0] sum);
    csum_of = SUM_TARGET - sum;
  endfunction
endpackage

// ### reply_parser.sv
// parses reply packets arriving from the reader
`timescale 1ns/1ps
`default_nettype none
module reply_parser (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  // configuration
  input  wire logic       i_csum_en,
  // received byte stream
  input  wire logic       i_rx_valid,
  input  wire logic [7:0] i_rx_data,
  // result
  rx_if.parser            res
);
  framer_pkg::rx_state_t st_ff;
  logic [15:0] size_ff;
  logic [15:0] left_ff;
  logic [7:0]  sum_ff;
  logic        first_ff;
  logic        second_ff;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_ff     <= framer_pkg::RX_HDR0;
      size_ff   <= '0;
      left_ff   <= '0;
      sum_ff    <= '0;
      first_ff  <= 1'b0;
      second_ff <= 1'b0;
      res.done     <= 1'b0;
      res.ok       <= 1'b0;
      res.is_err   <= 1'b0;
      res.code     <= '0;
      res.err_code <= '0;
      res.size     <= '0;
    end else begin
      res.done <= 1'b0;
      if (i_rx_valid) begin
        case (st_ff)
          framer_pkg::RX_HDR0: begin
            if (i_rx_data == framer_pkg::START_BYTE) st_ff <= framer_pkg::RX_HDR1;
          end
          framer_pkg::RX_HDR1: begin
            st_ff <= (i_rx_data == framer_pkg::START_BYTE) ? framer_pkg::RX_SZH
                                                            : framer_pkg::RX_HDR0;
          end
          framer_pkg::RX_SZH: begin
            size_ff[15:8] <= i_rx_data;
            sum_ff        <= i_rx_data;
            st_ff         <= framer_pkg::RX_SZL;
          end
          framer_pkg::RX_SZL: begin
            size_ff[7:0] <= i_rx_data;
            left_ff      <= {size_ff[15:8], i_rx_data};
            sum_ff       <= sum_ff + i_rx_data;
            first_ff     <= 1'b1;
            second_ff    <= 1'b0;
            // empty body is legal; csum or end follows at once
            if ({size_ff[15:8], i_rx_data} == 16'h0000) begin
              st_ff <= i_csum_en ? framer_pkg::RX_CSUM : framer_pkg::RX_END;
            end else begin
              st_ff <= framer_pkg::RX_BODY;
            end
          end
          framer_pkg::RX_BODY: begin
            // raw binary, no escaping: 02h/03h inside the body are data
            sum_ff  <= sum_ff + i_rx_data;
            left_ff <= left_ff - 16'h0001;
            if (first_ff) begin
              res.code   <= i_rx_data;
              res.is_err <= (i_rx_data == framer_pkg::ERR_FLAG);
              first_ff   <= 1'b0;
              second_ff  <= 1'b1;
            end else if (second_ff) begin
              res.err_code <= i_rx_data;
              second_ff    <= 1'b0;
            end
            if (left_ff == 16'h0001) begin
              st_ff <= i_csum_en ? framer_pkg::RX_CSUM : framer_pkg::RX_END;
            end
          end
          framer_pkg::RX_CSUM: begin
            sum_ff <= sum_ff + i_rx_data;
            st_ff  <= framer_pkg::RX_END;
          end
          framer_pkg::RX_END: begin
            res.done <= 1'b1;
            res.size <= size_ff;
            res.ok   <= (i_rx_data == framer_pkg::END_BYTE)
                        && (!i_csum_en || sum_ff == framer_pkg::SUM_TARGET);
            st_ff    <= framer_pkg::RX_HDR0;
          end
          default: st_ff <= framer_pkg::RX_HDR0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ### rx_if.sv
// reply-parser result carrier between the framer and its parser
`timescale 1ns/1ps
`default_nettype none
interface rx_if;
  logic       done;
  logic       ok;
  logic       is_err;
  logic [7:0] code;
  logic [7:0] err_code;
  logic [15:0] size;
  modport parser (output done, ok, is_err, code, err_code, size);
  modport user   (input  done, ok, is_err, code, err_code, size);
endinterface
`default_nettype wire

// ### tag_reader_model.sv
// behavioural reader: takes fill packets, fills its memory, replies
`timescale 1ns/1ps
`default_nettype none
module tag_reader_model #(
  parameter logic [7:0] SYNTAX_ERR = 8'h05,
  parameter logic [7:0] FAULT_CODE = 8'h07,
  parameter logic [7:0] CSUM_ERR   = 8'h09
) (
  input  wire logic       i_clk,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  output logic            o_tx_ready,
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_data,
  input  wire logic       i_csum_en,
  input  wire logic [1:0] i_mode
);
  logic [7:0] got [$];
  logic [7:0] rep [$];
  logic [7:0] mem [256];
  logic [7:0] s;
  logic [7:0] idx;
  logic       go = 1'b0;
  int         i;
  initial begin
    o_tx_ready = 1'b0;
    o_rx_valid = 1'b0;
    o_rx_data  = 8'h00;
  end
  // plain ready handshake only, control bytes may sit inside data
  always @(posedge i_clk) begin
    o_tx_ready <= i_tx_valid && !o_tx_ready;
    go <= 1'b0;
    if (i_tx_valid && o_tx_ready) begin
      got.push_back(i_tx_data);
      if (got.size() > 4 && got.size() == {got[2], got[3]} + 5 + i_csum_en) go <= 1'b1;
    end
  end
  always @(posedge go) begin
    s = 8'h00;
    for (i = 2; i < got.size() - 1; i++) s += got[i];
    rep = {8'h00, 8'h01, framer_pkg::FILL_CODE};
    if (i_csum_en && s != framer_pkg::SUM_TARGET) rep = {8'h00, 8'h02, 8'hff, CSUM_ERR};
    else if ({got[9], got[10]} == 16'h0000) rep = {8'h00, 8'h02, 8'hff, SYNTAX_ERR};
    else if (i_mode == 2'h1) rep = {8'h00, 8'h02, 8'hff, FAULT_CODE};
    else for (i = 0; i < {got[7], got[8]}; i++) begin
      idx = got[6] + i[7:0];
      mem[idx] = got[11];
    end
    s = 8'h00;
    foreach (rep[k]) s += rep[k];
    if (i_csum_en) rep.push_back((framer_pkg::SUM_TARGET - s) ^ {7'h0, i_mode == 2'h2});
    rep = {8'h02, 8'h02, rep, 8'h03};
    // mode 3 stays silent, standing for a fill that overran its time
    if (i_mode != 2'h3) foreach (rep[k]) begin
      @(posedge i_clk) o_rx_valid <= 1'b1;
      o_rx_data <= rep[k];
      @(posedge i_clk) o_rx_valid <= 1'b0;
      o_rx_data <= ~rep[k];
    end
  end
endmodule
`default_nettype wire
